// [rtl/dfp_defines.vh]
// shared offsets, field layouts, reset values and timing for the dc feed parameter bank
`ifndef DFP_DEFINES_VH
`define DFP_DEFINES_VH

// word geometry
`define DFP_DATA_W 16
`define DFP_ADDR_W 4
`define DFP_DEPTH 16

// word offsets on the register port
`define DFP_OFS_OPEN_CIRCUIT 4'h0
`define DFP_OFS_OFFHOOK_OFFSET 4'h1
`define DFP_OFS_LOW_DELTA 4'h2
`define DFP_OFS_HIGH_DELTA 4'h3
`define DFP_OFS_FEED_OVERHEAD 4'h5
`define DFP_OFS_RING_OVERHEAD 4'h6
`define DFP_OFS_TRACKED_OC 4'hA
`define DFP_OFS_RING_READING 4'hC
`define DFP_OFS_STATUS 4'hF

// writable bit masks; 15-bit words keep bit 15 at zero
`define DFP_MASK_15BIT 16'h7FFF
`define DFP_MASK_16BIT 16'hFFFF

// reset value of every word
`define DFP_RST_WORD 16'h0000

// usable programming span, 63.3 V at 4.907 mV per code
`define DFP_SPAN_MAX_CODE 16'h3263

// status word bit positions
`define DFP_ST_OFFHOOK 0
`define DFP_ST_OFFSET_ON 1
`define DFP_ST_BAT_SAG 2
`define DFP_ST_FEED_STRETCH 3
`define DFP_ST_RING_STRETCH 4

// timing: core clock and ring-lead refresh rate, both in hertz
`define DFP_CLK_HZ 20000000
`define DFP_RING_RATE_HZ 800
`define DFP_RING_REFRESH_CYCLES (`DFP_CLK_HZ / `DFP_RING_RATE_HZ)

`endif

// [rtl/dfp_rate_tick.v]
// divider that emits a one-cycle enable pulse every CYCLES clocks
`timescale 1ns/1ps
module dfp_rate_tick #(
	parameter CYCLES = 25000
) (
	// clock and reset
	input wire clk,
	input wire sys_rst,
	// enable pulse
	output reg tick
);

localparam W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
localparam [31:0] LAST_FULL = CYCLES - 1;
localparam [W-1:0] LAST = LAST_FULL[W-1:0];

reg [W-1:0] count;

////////////////////////////////////////////////////////////////////////////////
// free-running count, pulse on wrap
always @(posedge clk or posedge sys_rst) begin
	if (sys_rst) begin
		count <= {W{1'b0}};
		tick <= 1'b0;
	end else if (count == LAST) begin
		count <= {W{1'b0}};
		tick <= 1'b1;
	end else begin
		count <= count + {{(W-1){1'b0}}, 1'b1};
		tick <= 1'b0;
	end
end

endmodule

// [rtl/dfp_word_ram.v]
// word store with bus write, per-word hardware update and registered read
`timescale 1ns/1ps
`include "dfp_defines.vh"
module dfp_word_ram #(
	parameter DW = 16,
	parameter AW = 4,
	parameter DEPTH = 16,
	parameter [DEPTH-1:0] MAPPED = {DEPTH{1'b1}},
	parameter [DEPTH*DW-1:0] WR_MASK = {(DEPTH*DW){1'b1}}
) (
	// clock and reset
	input wire clk,
	input wire sys_rst,
	// software side
	input wire wr_en,
	input wire [AW-1:0] wr_addr,
	input wire [DW-1:0] wr_data,
	input wire rd_en,
	input wire [AW-1:0] rd_addr,
	output reg [DW-1:0] rd_data,
	// hardware update side, wins over software on the same word
	input wire [DEPTH-1:0] hw_we,
	input wire [DEPTH*DW-1:0] hw_data,
	// every word, for the feed logic
	output wire [DEPTH*DW-1:0] words
);

genvar i;

////////////////////////////////////////////////////////////////////////////////
// one register per word, unmapped words held at zero
generate
	for (i = 0; i < DEPTH; i = i + 1) begin : g_word
		reg [DW-1:0] word;
		wire [DW-1:0] mask = WR_MASK[i*DW +: DW];
		// zero on reset; hardware update beats a same-cycle write
		always @(posedge clk or posedge sys_rst) begin
			if (sys_rst) begin
				word <= `DFP_RST_WORD;
			end else if (!MAPPED[i]) begin
				word <= `DFP_RST_WORD;
			end else if (hw_we[i]) begin
				word <= hw_data[i*DW +: DW] & mask;
			end else if (wr_en && (wr_addr == i)) begin
				word <= wr_data & mask;
			end
		end
		assign words[i*DW +: DW] = word;
	end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// read data valid only in the cycle after the strobe; unmapped reads zero
always @(posedge clk or posedge sys_rst) begin
	if (sys_rst) begin
		rd_data <= `DFP_RST_WORD;
	end else if (rd_en) begin
		rd_data <= words[rd_addr*DW +: DW];
	end else begin
		rd_data <= `DFP_RST_WORD;
	end
end

endmodule

// [rtl/dfp_param_bank.v]
// dc feed parameter bank: threshold hook state, overhead tracking, ring-lead refresh
//
// Notes on behaviour
// - offset applied once line falls below open-circuit setting by more than low delta.
// - low delta used only on-hook to off-hook; upper delta governs the return.
// - low delta scaled 4.907 mV per code, usable span 0 to 63.3 V.
// - tracking word reports actual on-hook voltage when battery sags too far.
// - feed overhead is ring-to-battery margin, tip-to-ground in reverse polarity.
// - effective feed overhead follows battery but never drops below programmed value.
// - ringing overhead is margin between negative ringing peak and high battery rail.
// - effective ringing overhead follows battery, keeping programmed value as minimum.
// - ring-to-ground sample stored as 16-bit word, 4.907 mV per code, to 160.788 V.
// - ring-lead word refreshed at 800 Hz, two's complement.
// - low delta, tracking, ringing overhead and ring-lead words reset to zero.
// - off-hook offset is added to the programmed open-circuit setting.
// - offset removed off-hook to on-hook once line rises above setting by upper delta.
`timescale 1ns/1ps
`include "dfp_defines.vh"
module dfp_param_bank #(
	parameter RING_REFRESH_CYCLES = `DFP_RING_REFRESH_CYCLES
) (
	// clock and reset
	input wire clk,
	input wire sys_rst,
	// register port
	input wire [`DFP_ADDR_W-1:0] reg_addr,
	input wire [`DFP_DATA_W-1:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output wire [`DFP_DATA_W-1:0] reg_rdata,
	// monitor converter results, same clock, 4.907 mV per code
	input wire [`DFP_DATA_W-1:0] line_voltage,
	input wire [`DFP_DATA_W-1:0] battery_voltage,
	input wire [`DFP_DATA_W-1:0] high_battery_rail,
	// ringing measurements, same clock
	input wire [`DFP_DATA_W-1:0] ring_peak_level,
	input wire [`DFP_DATA_W-1:0] ring_sample,
	// line polarity from the feed state
	input wire reverse_polarity,
	// hook state toward the linefeed loop
	output reg offhook,
	output reg offset_applied,
	// feed levels toward the linefeed loop
	output reg [`DFP_DATA_W-1:0] voc_target,
	output reg [`DFP_DATA_W-1:0] eff_feed_overhead,
	output reg [`DFP_DATA_W-1:0] eff_ring_overhead,
	output reg feed_margin_on_tip
);

// widths from the shared defines
localparam DW = `DFP_DATA_W;
localparam DEPTH = `DFP_DEPTH;

// hook states
localparam [0:0] ST_ONHOOK = 1'b0;
localparam [0:0] ST_OFFHOOK = 1'b1;

// word map: mapped words and writable masks
// unmapped offsets read zero and drop writes
localparam [DEPTH-1:0] MAPPED = (16'h0001 << `DFP_OFS_OPEN_CIRCUIT)
	| (16'h0001 << `DFP_OFS_OFFHOOK_OFFSET)
	| (16'h0001 << `DFP_OFS_LOW_DELTA)
	| (16'h0001 << `DFP_OFS_HIGH_DELTA)
	| (16'h0001 << `DFP_OFS_FEED_OVERHEAD)
	| (16'h0001 << `DFP_OFS_RING_OVERHEAD)
	| (16'h0001 << `DFP_OFS_TRACKED_OC)
	| (16'h0001 << `DFP_OFS_RING_READING)
	| (16'h0001 << `DFP_OFS_STATUS);

localparam [DEPTH*DW-1:0] WR_MASK = {
	`DFP_MASK_16BIT, // 0xF status
	`DFP_MASK_16BIT, // 0xE
	`DFP_MASK_16BIT, // 0xD
	`DFP_MASK_16BIT, // 0xC ring-lead reading
	`DFP_MASK_16BIT, // 0xB
	`DFP_MASK_16BIT, // 0xA tracked open circuit
	`DFP_MASK_16BIT, // 0x9
	`DFP_MASK_16BIT, // 0x8
	`DFP_MASK_16BIT, // 0x7
	`DFP_MASK_15BIT, // 0x6 ringing overhead
	`DFP_MASK_15BIT, // 0x5 feed overhead
	`DFP_MASK_16BIT, // 0x4
	`DFP_MASK_16BIT, // 0x3 upper delta
	`DFP_MASK_16BIT, // 0x2 low delta
	`DFP_MASK_15BIT, // 0x1 off-hook offset
	`DFP_MASK_15BIT}; // 0x0 open-circuit setting

////////////////////////////////////////////////////////////////////////////////
// helpers

// fetch one word out of the flat bank
function [DW-1:0] word_at;
	input [DEPTH*DW-1:0] bank;
	input [3:0] idx;
	begin
		word_at = bank[idx*DW +: DW];
	end
endfunction

// a minus b, floored at zero
function [DW-1:0] sat_sub;
	input [DW-1:0] a;
	input [DW-1:0] b;
	begin
		sat_sub = (a > b) ? (a - b) : {DW{1'b0}};
	end
endfunction

// a plus b, held at full scale
function [DW-1:0] sat_add;
	input [DW-1:0] a;
	input [DW-1:0] b;
	reg [DW:0] sum;
	begin
		sum = {1'b0, a} + {1'b0, b};
		sat_add = sum[DW] ? {DW{1'b1}} : sum[DW-1:0];
	end
endfunction

// clamp a programmed word into the usable 63.3 V span
function [DW-1:0] span_clamp;
	input [DW-1:0] a;
	begin
		span_clamp = (a > `DFP_SPAN_MAX_CODE) ? `DFP_SPAN_MAX_CODE : a;
	end
endfunction

// hook state decode, shared by the target, flag and tracking logic
function hook_is_off;
	input [0:0] state;
	begin
		hook_is_off = (state == ST_OFFHOOK);
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// word store and refresh divider

// flat view of every word, and the hardware write lanes
wire [DEPTH*DW-1:0] words;
reg [DEPTH-1:0] hw_we;
reg [DEPTH*DW-1:0] hw_data;
wire ring_tick;

// reads come back registered, one cycle after the strobe
dfp_word_ram #(
	.DW(DW),
	.AW(`DFP_ADDR_W),
	.DEPTH(DEPTH),
	.MAPPED(MAPPED),
	.WR_MASK(WR_MASK)
) u_ram (
	.clk(clk),
	.sys_rst(sys_rst),
	.wr_en(reg_wr),
	.wr_addr(reg_addr),
	.wr_data(reg_wdata),
	.rd_en(reg_rd),
	.rd_addr(reg_addr),
	.rd_data(reg_rdata),
	.hw_we(hw_we),
	.hw_data(hw_data),
	.words(words)
);

// free-running divider, so ticks are not aligned to writes
// 800 Hz refresh
dfp_rate_tick #(
	.CYCLES(RING_REFRESH_CYCLES)
) u_tick (
	.clk(clk),
	.sys_rst(sys_rst),
	.tick(ring_tick)
);

////////////////////////////////////////////////////////////////////////////////
// programmed words as seen by the feed logic

// setting and offset clamped to the usable span
wire [DW-1:0] oc_setting = span_clamp(word_at(words, `DFP_OFS_OPEN_CIRCUIT));
wire [DW-1:0] oc_offset = span_clamp(word_at(words, `DFP_OFS_OFFHOOK_OFFSET));
// same 4.907 mV code as the line measurement, so no rescale
wire [DW-1:0] low_delta = span_clamp(word_at(words, `DFP_OFS_LOW_DELTA));
wire [DW-1:0] high_delta = span_clamp(word_at(words, `DFP_OFS_HIGH_DELTA));
// overheads are floors only, so no clamp is needed
wire [DW-1:0] feed_ovh = word_at(words, `DFP_OFS_FEED_OVERHEAD);
wire [DW-1:0] ring_ovh = word_at(words, `DFP_OFS_RING_OVERHEAD);

////////////////////////////////////////////////////////////////////////////////
// hook hysteresis thresholds

// entry point sits low delta under the setting
wire [DW-1:0] entry_level = sat_sub(oc_setting, low_delta);
// return point sits upper delta over the setting
wire [DW-1:0] return_level = sat_add(oc_setting, high_delta);
// saturating levels cannot wrap past zero or full scale
wire below_entry = line_voltage < entry_level;
wire above_return = line_voltage > return_level;

// one-bit hook state: on-hook or off-hook
reg [0:0] hook_state;
reg [0:0] next_hook_state;

// each threshold only looked at in its own direction
always @* begin
	next_hook_state = hook_state;
	case (hook_state)
		ST_ONHOOK: begin
			// drop past the low delta applies the offset
			if (below_entry) begin
				next_hook_state = ST_OFFHOOK;
			end
		end
		ST_OFFHOOK: begin
			// rise past the upper delta removes it
			if (above_return) begin
				next_hook_state = ST_ONHOOK;
			end
		end
		default: begin
			// one-bit state, so only reachable on a fault
			next_hook_state = ST_ONHOOK;
		end
	endcase
end

// hook state register; offhook mirrors it one-for-one
always @(posedge clk or posedge sys_rst) begin
	if (sys_rst) begin
		hook_state <= ST_ONHOOK;
	end else begin
		hook_state <= next_hook_state;
	end
end

////////////////////////////////////////////////////////////////////////////////
// open-circuit target and overhead tracking

// offset stacks on top of the programmed setting
wire [DW-1:0] next_voc_target = hook_is_off(next_hook_state) ?
	sat_add(oc_setting, oc_offset) : oc_setting;

// headroom the battery leaves after the feed overhead
wire [DW-1:0] bat_headroom = sat_sub(battery_voltage, feed_ovh);
// sag is judged against the setting, not the off-hook target
wire bat_sag = bat_headroom < oc_setting;

// overhead grows with battery, floor at programmed value
wire [DW-1:0] feed_track = sat_sub(battery_voltage, next_voc_target);
wire feed_stretch = feed_track > feed_ovh;
wire [DW-1:0] next_eff_feed = feed_stretch ? feed_track : feed_ovh;

// ringing overhead against the high rail, floor at programmed value
wire [DW-1:0] ring_track = sat_sub(high_battery_rail, ring_peak_level);
wire ring_stretch = ring_track > ring_ovh;
wire [DW-1:0] next_eff_ring = ring_stretch ? ring_track : ring_ovh;

// hook flags, registered from the next state, so they match hook_state with no lag
always @(posedge clk or posedge sys_rst) begin
	if (sys_rst) begin
		offhook <= 1'b0;
		offset_applied <= 1'b0;
	end else begin
		offhook <= hook_is_off(next_hook_state);
		offset_applied <= hook_is_off(next_hook_state);
	end
end

// open-circuit target, setting plus offset while off-hook
always @(posedge clk or posedge sys_rst) begin
	if (sys_rst) begin
		voc_target <= `DFP_RST_WORD;
	end else begin
		voc_target <= next_voc_target;
	end
end

// effective overheads, each floored at its programmed word
always @(posedge clk or posedge sys_rst) begin
	if (sys_rst) begin
		eff_feed_overhead <= `DFP_RST_WORD;
		eff_ring_overhead <= `DFP_RST_WORD;
	end else begin
		eff_feed_overhead <= next_eff_feed;
		// ringing margin to the high rail
		eff_ring_overhead <= next_eff_ring;
	end
end

// margin measured ring-to-battery, or tip-to-ground when reversed
always @(posedge clk or posedge sys_rst) begin
	if (sys_rst) begin
		feed_margin_on_tip <= 1'b0;
	end else begin
		feed_margin_on_tip <= reverse_polarity;
	end
end

////////////////////////////////////////////////////////////////////////////////
// hardware updates into the store

// sagged battery reports the real level, else the setting holds
wire [DW-1:0] tracked_word = bat_sag ? bat_headroom : oc_setting;
// the word only moves while on-hook, so an off-hook dip never shows
wire track_now = ring_tick && !hook_is_off(hook_state);

reg [DW-1:0] status_word;

// status bits mirror live state; software sees them one cycle late
always @* begin
	status_word = {DW{1'b0}};
	status_word[`DFP_ST_OFFHOOK] = offhook;
	status_word[`DFP_ST_OFFSET_ON] = offset_applied;
	status_word[`DFP_ST_BAT_SAG] = bat_sag;
	status_word[`DFP_ST_FEED_STRETCH] = feed_stretch;
	status_word[`DFP_ST_RING_STRETCH] = ring_stretch;
end

// measurement updates win over any software write
always @* begin
	hw_we = {DEPTH{1'b0}};
	hw_we[`DFP_OFS_TRACKED_OC] = track_now;
	hw_we[`DFP_OFS_RING_READING] = ring_tick;
	// status mirrors live state every cycle
	hw_we[`DFP_OFS_STATUS] = 1'b1;
end

// data lanes; a lane whose enable is low is ignored by the store
always @* begin
	hw_data = {(DEPTH*DW){1'b0}};
	hw_data[`DFP_OFS_TRACKED_OC*DW +: DW] = tracked_word;
	// raw two's complement sample, 4.907 mV per code
	hw_data[`DFP_OFS_RING_READING*DW +: DW] = ring_sample;
	hw_data[`DFP_OFS_STATUS*DW +: DW] = status_word;
end

endmodule

// [test/dfp_param_bank_properties.sv]
// port checker for the dc feed parameter bank, with its bind
`timescale 1ns/1ps
module dfp_param_bank_chk #(
	parameter RING_REFRESH_CYCLES = 8
) (
	// clock and reset
	input wire clk,
	input wire sys_rst,
	// register port
	input wire [3:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [15:0] reg_rdata,
	// measurements
	input wire [15:0] line_voltage,
	input wire [15:0] battery_voltage,
	input wire [15:0] high_battery_rail,
	input wire [15:0] ring_peak_level,
	input wire [15:0] ring_sample,
	input wire reverse_polarity,
	// feed controls
	input wire offhook,
	input wire offset_applied,
	input wire [15:0] voc_target,
	input wire [15:0] eff_feed_overhead,
	input wire [15:0] eff_ring_overhead,
	input wire feed_margin_on_tip
);
	integer i;
	reg [15:0] sh [0:7];
	// thresholds are limited to the usable span
	function [16:0] cl(input [15:0] v);
		cl = (v > 16'h3263) ? 17'h03263 : {1'b0, v};
	endfunction
	wire [16:0] ent = (cl(sh[0]) > cl(sh[2])) ? cl(sh[0]) - cl(sh[2]) : 17'h00000;
	wire lt_ent = {1'b0, line_voltage} < ent;
	wire gt_ext = {1'b0, line_voltage} > cl(sh[0]) + cl(sh[3]);
	wire [15:0] rsub = (high_battery_rail > ring_peak_level) ?
		high_battery_rail - ring_peak_level : 16'h0000;
	wire [15:0] ring_exp = (rsub > sh[6]) ? rsub : sh[6];
	wire map_rw = reg_addr < 4'h7 && reg_addr != 4'h4;
	wire map_no = reg_addr == 4'h4 || (reg_addr > 4'h6 && reg_addr < 4'hF &&
		reg_addr != 4'hA && reg_addr != 4'hC);
	wire [15:0] rd_exp = sh[reg_addr[2:0]];
	wire [15:0] feed_w = sh[5];
	wire [16:0] voc_on = cl(sh[0]) + cl(sh[1]);
	wire [16:0] voc_off = cl(sh[0]);
	// shadow of the plain words; hardware never touches these
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (i = 0; i < 8; i = i + 1)
				sh[i] <= 16'h0000;
		end else if (reg_wr && map_rw) begin
			sh[reg_addr[2:0]] <= reg_wdata & ((reg_addr[3:1] == 3'h1) ? 16'hFFFF : 16'h7FFF);
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data not zero outside a read");
	a_rdata_word_match: assert property (reg_rd && map_rw |=> reg_rdata == $past(rd_exp))
		else $error("read data differs from stored word");
	a_rdata_unmapped: assert property (reg_rd && map_no |=> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	a_offset_with_hook: assert property (offset_applied == offhook)
		else $error("offset flag differs from hook state");
	a_hook_entry_point: assert property (!offhook |=> offhook == $past(lt_ent))
		else $error("wrong off-hook entry");
	a_hook_exit_point: assert property (offhook |=> offhook != $past(gt_ext))
		else $error("wrong on-hook return");
	a_voc_target_sum: assert property (voc_target == (offhook ? $past(voc_on) : $past(voc_off)))
		else $error("open-circuit target wrong");
	a_ring_overhead_min: assert property (eff_ring_overhead == $past(ring_exp))
		else $error("ringing overhead wrong");
	a_feed_overhead_floor: assert property (eff_feed_overhead >= $past(feed_w))
		else $error("feed overhead below setting");
	a_margin_tip_side: assert property (feed_margin_on_tip == $past(reverse_polarity))
		else $error("margin side does not follow polarity");
	c_hook_rise: cover property ($rose(offhook));
	c_hook_fall: cover property ($fell(offhook));
	c_ring_read: cover property (reg_rd && reg_addr == 4'hC);
endmodule

bind dfp_param_bank dfp_param_bank_chk #(.RING_REFRESH_CYCLES(RING_REFRESH_CYCLES)) chk_u (
	.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_voltage(line_voltage),
	.battery_voltage(battery_voltage), .high_battery_rail(high_battery_rail),
	.ring_peak_level(ring_peak_level), .ring_sample(ring_sample),
	.reverse_polarity(reverse_polarity), .offhook(offhook), .offset_applied(offset_applied),
	.voc_target(voc_target), .eff_feed_overhead(eff_feed_overhead),
	.eff_ring_overhead(eff_ring_overhead), .feed_margin_on_tip(feed_margin_on_tip));

// [test/tb.sv]
// self-checking bench for the dc feed parameter bank
`timescale 1ns/1ps
module tb;
	reg clk = 1'b0;
	reg sys_rst = 1'b1;
	reg [3:0] reg_addr = 4'h0;
	reg [15:0] reg_wdata = 16'h0000;
	reg reg_wr = 1'b0;
	reg reg_rd = 1'b0;
	reg [15:0] line_voltage = 16'h0000, battery_voltage = 16'h0000, ring_sample = 16'h0000;
	reg [15:0] high_battery_rail = 16'h0000, ring_peak_level = 16'h0000;
	reg reverse_polarity = 1'b0;
	wire [15:0] reg_rdata, voc_target, eff_feed_overhead, eff_ring_overhead;
	wire offhook, offset_applied, feed_margin_on_tip;
	integer errors = 0, n_tests = 0, seed = 33522, cyc = 0, i;
	reg [15:0] got, a16, d16;
	// 20 MHz clock
	always #25 clk = ~clk;
	// short refresh period keeps the run brief
	dfp_param_bank #(.RING_REFRESH_CYCLES(8)) dut_u (
		.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_voltage(line_voltage),
		.battery_voltage(battery_voltage), .high_battery_rail(high_battery_rail),
		.ring_peak_level(ring_peak_level), .ring_sample(ring_sample),
		.reverse_polarity(reverse_polarity), .offhook(offhook), .offset_applied(offset_applied),
		.voc_target(voc_target), .eff_feed_overhead(eff_feed_overhead),
		.eff_ring_overhead(eff_ring_overhead), .feed_margin_on_tip(feed_margin_on_tip));
	task test_done;
		begin
			if (errors == 0 && n_tests > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	task chk(input [15:0] g, input [15:0] e);
		begin
			n_tests = n_tests + 1;
			if (g !== e) begin
				errors = errors + 1;
				$display("Error at %0t: got %h expected %h", $time, g, e);
			end
		end
	endtask
	// one-cycle strobes, changed just after the edge
	task wr(input [3:0] a, input [15:0] d);
		begin
			@(posedge clk);
			reg_wr <= 1'b1;
			reg_addr <= a;
			reg_wdata <= d;
			@(posedge clk);
			reg_wr <= 1'b0;
		end
	endtask
	task rdchk(input [3:0] a, input [15:0] e);
		begin
			@(posedge clk);
			reg_rd <= 1'b1;
			reg_addr <= a;
			@(posedge clk);
			reg_rd <= 1'b0;
			#1 chk(reg_rdata, e);
		end
	endtask
	// hook step: new line level, result two edges later
	task hk(input [15:0] lv, input h, input [15:0] v);
		begin
			@(posedge clk);
			line_voltage <= lv;
			repeat (2) @(posedge clk);
			#1 chk({15'h0000, offhook}, {15'h0000, h});
			chk(voc_target, v);
		end
	endtask
	// programmed margin, raised when the rail difference is larger
	function [15:0] fmx(input [15:0] w, input [15:0] a, input [15:0] b);
		fmx = (a > b && a - b > w) ? a - b : w;
	endfunction
	// hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			errors = errors + 1;
			test_done;
		end
	end
	initial begin
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		// reset values, status word left out
		for (i = 0; i < 15; i = i + 1)
			rdchk(i[3:0], 16'h0000);
		// random plain words, kept inside the usable span
		for (i = 0; i < 24; i = i + 1) begin
			a16 = {$random(seed)} % 7;
			if (a16 == 16'h0004)
				a16 = 16'h0002;
			d16 = $random(seed) & 16'h1FFF;
			wr(a16[3:0], d16);
			rdchk(a16[3:0], d16);
		end
		wr(4'h5, 16'hFFFF);
		rdchk(4'h5, 16'h7FFF);
		wr(4'h6, 16'hFFFF);
		rdchk(4'h6, 16'h7FFF);
		wr(4'h2, 16'hFFFF);
		rdchk(4'h2, 16'hFFFF);
		wr(4'h4, 16'h1234);
		rdchk(4'h4, 16'h0000);
		// hook thresholds at their exact boundaries
		wr(4'h0, 16'h1000);
		wr(4'h1, 16'h0200);
		wr(4'h2, 16'h0100);
		wr(4'h3, 16'h0080);
		hk(16'hFFFF, 1'b0, 16'h1000);
		hk(16'h1000, 1'b0, 16'h1000);
		hk(16'h0F00, 1'b0, 16'h1000);
		hk(16'h0EFF, 1'b1, 16'h1200);
		hk(16'h0E00, 1'b1, 16'h1200);
		hk(16'h1080, 1'b1, 16'h1200);
		hk(16'h1081, 1'b0, 16'h1000);
		// a low delta of eight volts moves the entry point
		wr(4'h2, 16'h065E);
		hk(16'h09A2, 1'b0, 16'h1000);
		hk(16'h09A1, 1'b1, 16'h1200);
		hk(16'hFFFF, 1'b0, 16'h1000);
		// overheads follow the rails but keep their floors
		wr(4'h5, 16'h0100);
		wr(4'h6, 16'h0200);
		for (i = 0; i < 12; i = i + 1) begin
			@(posedge clk);
			battery_voltage <= $random(seed) & 16'h3FFF;
			high_battery_rail <= $random(seed) & 16'h3FFF;
			ring_peak_level <= $random(seed) & 16'h3FFF;
			reverse_polarity <= $random(seed);
			repeat (2) @(posedge clk);
			#1 chk(eff_ring_overhead, fmx(16'h0200, high_battery_rail, ring_peak_level));
			chk(eff_feed_overhead, fmx(16'h0100, battery_voltage, 16'h1000));
			chk({15'h0000, feed_margin_on_tip}, {15'h0000, reverse_polarity});
		end
		// refresh overwrites a software write; sagging battery tracked
		@(posedge clk);
		ring_sample <= 16'hF123;
		battery_voltage <= 16'h0800;
		wr(4'hC, 16'h5555);
		repeat (10) @(posedge clk);
		rdchk(4'hC, 16'hF123);
		rdchk(4'hA, 16'h0700);
		// status: sagged battery, feed not stretched, ring stretch from the rails
		rdchk(4'hF, {11'h000, fmx(16'h0200, high_battery_rail, ring_peak_level) != 16'h0200, 4'h4});
		test_done;
	end
endmodule
